// ### drh_pkg.sv
// package: constants and types of the refresh scheduler and bus hold unit
`default_nettype none
package drh_pkg;
  // ***********************************************************
  // register map and field layout
  // ***********************************************************
  localparam logic [6:0]  DRH_OFF_REFRESH = 7'h06;
  localparam logic [6:0]  DRH_OFF_MEMCTL  = 7'h08;
  localparam int          DRH_SCALAR_W    = 6;
  localparam logic [15:0] DRH_REFRESH_RST = 16'h0012;
  localparam logic [15:0] DRH_MEMCTL_RST  = 16'h0000;
  localparam logic [15:0] DRH_REFRESH_MSK = 16'h003F;
  // ***********************************************************
  // refresh timing and queue
  // ***********************************************************
  localparam int          DRH_PRESCALE    = 16;
  localparam int          DRH_ROW_W       = 10;
  localparam logic [1:0]  DRH_QUEUE_MAX   = 2'h3;
  localparam logic [1:0]  DRH_RESET_REFS  = 2'h3;
  localparam logic [2:0]  DRH_REF_LEN     = 3'h4;
  // ***********************************************************
  // master cycle lengths at zero wait states and release gap
  // ***********************************************************
  localparam logic [2:0]  DRH_LEN_SINGLE  = 3'h4;
  localparam logic [2:0]  DRH_LEN_RMW     = 3'h6;
  localparam logic [2:0]  DRH_LEN_BURST   = 3'h2;
  localparam logic [1:0]  DRH_GAP_LEN     = 2'h2;
  localparam logic [3:0]  DRH_BLOCK_MIN   = 4'h2;
  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [1:0] {
    DRH_MODE_SYNC_A = 2'h0,
    DRH_MODE_SYNC_B = 2'h1,
    DRH_MODE_ASYNC  = 2'h2
  } drh_mode_t;
  typedef enum logic [1:0] {
    DRH_KIND_SINGLE = 2'h0,
    DRH_KIND_RMW    = 2'h1,
    DRH_KIND_BURST  = 2'h2
  } drh_kind_t;
  typedef enum logic [2:0] {
    DRH_ST_IDLE = 3'h0,
    DRH_ST_WAIT = 3'h1,
    DRH_ST_ACC  = 3'h3,
    DRH_ST_REF  = 3'h2,
    DRH_ST_GAP  = 3'h6
  } drh_state_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } drh_reg_req_t;
endpackage : drh_pkg
`default_nettype wire

// ### drh_refresh_hold.sv
// module: refresh scheduler and system bus hold arbitration
//
// Operation
// [R1] request every sixteen times scalar-plus-one clocks
// [R2] scalar all ones stops refresh
// [R3] one row per refresh, ten-bit row
// [R4] pending refresh runs after current bus cycle
// [R5] block transfers break only at double words; past sixteen beats the code can break after any beat
// [R6] two master cycles after acknowledge first; without block_in the code refreshes after one
// [R7] queue three requests, run them back-to-back
// [R8] three refreshes after reset, nothing else
// [R9] strap pins pick bus mode at reset
// [R10] master plus slave or slave only
// [R11] master signalling always first synchronous style
// [R12] raise hold request, wait for acknowledge
// [R13] first access cycle right after acknowledge
// [R14] single four, rmw six, burst two cycles
// [R15] hold request stays while system work pends
// [R16] local access next cycle after release; after early release the code first runs the two-cycle gap
// [R17] early release: finish access, drop request
// [R18] re-request two cycles after drop; the code waits two only after early release in an access, else one
// [R19] host must see short request drop
// [R20] write protect locks both control registers
// [R21] host writes memory control in one go
// [R22] host waits for memory control setup
// [R23] interval reloads scalar on each expiry
`default_nettype none
module drh_refresh_hold (
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  reset_n_in,
  // register port
  input  wire drh_pkg::drh_reg_req_t reg_req_in,
  output var  logic [15:0]           reg_rdata_out,
  input  wire logic                  wp_refresh_in,
  input  wire logic                  wp_memctl_in,
  output var  logic [15:0]           memctl_out,
  // strap pins and configuration
  input  wire logic                  byte_high_enable_strap_in,
  input  wire logic                  memory_io_strap_in,
  input  wire logic                  master_enable_in,
  output var  drh_pkg::drh_mode_t    bus_mode_out,
  output var  drh_pkg::drh_mode_t    master_style_out,
  // internal processor requests
  input  wire logic                  sys_req_in,
  input  wire drh_pkg::drh_kind_t    sys_kind_in,
  input  wire logic                  block_in,
  input  wire logic                  local_req_in,
  output var  logic                  sys_done_out,
  output var  logic                  local_go_out,
  output var  logic                  master_busy_out,
  // system bus hold handshake
  output var  logic                  hold_request_out,
  input  wire logic                  hold_acknowledge_in,
  // refresh status
  output var  logic                  refresh_go_out,
  output var  logic [9:0]            refresh_row_out,
  output var  logic [1:0]            refresh_pending_out
);
  import drh_pkg::*;

  // ***********************************************************
  // helpers
  // ***********************************************************
  // cycle count of one master access, minus one
  function automatic logic [2:0] acc_len(input drh_kind_t k);
    case (k)
      DRH_KIND_RMW:   acc_len = DRH_LEN_RMW - 3'h1;
      DRH_KIND_BURST: acc_len = DRH_LEN_BURST - 3'h1;
      default:        acc_len = DRH_LEN_SINGLE - 3'h1;
    endcase
  endfunction

  logic [15:0]             refresh_q;
  logic [15:0]             memctl_q;
  logic [3:0]              pre_q;
  logic [DRH_SCALAR_W-1:0] ivl_q;
  logic                    tick;
  logic [1:0]              queue_q;
  logic [2:0]              cnt_q;
  logic [1:0]              gap_q;
  logic [3:0]              beats_q;
  logic                    strap_done_q;
  drh_state_t              state_q;
  logic                    acc_end;
  logic                    ref_end;
  logic                    ref_ok;
  logic                    disabled;

  assign disabled = refresh_q[DRH_SCALAR_W-1:0] == DRH_REFRESH_MSK[5:0];
  assign acc_end  = state_q == DRH_ST_ACC && cnt_q == 3'h0;
  assign ref_end  = state_q == DRH_ST_REF && cnt_q == 3'h0;
  // beat count before the increment: odd means a double word ends now, within the first sixteen beats
  assign ref_ok   = !block_in || (beats_q[0] && beats_q >= 4'h1);

  // ***********************************************************
  // register port
  // ***********************************************************
  // writes, each register locked by its protect input
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      refresh_q <= DRH_REFRESH_RST;
      memctl_q  <= DRH_MEMCTL_RST;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == DRH_OFF_REFRESH && !wp_refresh_in) begin
        refresh_q <= reg_req_in.wdata & DRH_REFRESH_MSK; // see [R20]
      end
      if (reg_req_in.addr == DRH_OFF_MEMCTL && !wp_memctl_in) begin
        memctl_q <= reg_req_in.wdata; // see [R20]
      end
    end
  end

  // read data, reserved bits zero, unmapped reads zero
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        DRH_OFF_REFRESH: reg_rdata_out <= refresh_q;
        DRH_OFF_MEMCTL:  reg_rdata_out <= memctl_q;
        default:         reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      memctl_out <= DRH_MEMCTL_RST;
    end else begin
      memctl_out <= memctl_q;
    end
  end

  // ***********************************************************
  // strap capture
  // ***********************************************************
  // straps caught on the first edge after reset release
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_done_q     <= 1'b0;
      bus_mode_out     <= DRH_MODE_SYNC_A;
      master_style_out <= DRH_MODE_SYNC_A;
    end else begin
      master_style_out <= DRH_MODE_SYNC_A; // see [R11]
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        if (!byte_high_enable_strap_in) begin
          bus_mode_out <= DRH_MODE_ASYNC; // see [R9]
        end else if (memory_io_strap_in) begin
          bus_mode_out <= DRH_MODE_SYNC_B; // see [R9]
        end else begin
          bus_mode_out <= DRH_MODE_SYNC_A; // see [R9]
        end
      end
    end
  end

  // ***********************************************************
  // refresh timing
  // ***********************************************************
  // fixed divide by sixteen, then scalar-plus-one interval
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre_q <= 4'h0;
      ivl_q <= DRH_REFRESH_RST[DRH_SCALAR_W-1:0];
    end else begin
      pre_q <= pre_q + 4'h1; // see [R1]
      if (pre_q == 4'(DRH_PRESCALE - 1)) begin
        if (ivl_q == '0) begin
          ivl_q <= refresh_q[DRH_SCALAR_W-1:0]; // see [R23]
        end else begin
          ivl_q <= ivl_q - 1'b1;
        end
      end
    end
  end

  assign tick = pre_q == 4'(DRH_PRESCALE - 1) && ivl_q == '0 &&
                !disabled; // see [R2]

  // queue of pending refreshes, preloaded with the reset burst
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      queue_q <= DRH_RESET_REFS; // see [R8]
    end else if (tick && !ref_end && queue_q != DRH_QUEUE_MAX) begin
      queue_q <= queue_q + 2'h1; // see [R7]
    end else if (ref_end && !tick) begin
      queue_q <= queue_q - 2'h1;
    end
  end

  // row address advances once per refresh
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      refresh_row_out <= '0;
    end else if (ref_end) begin
      refresh_row_out <= refresh_row_out + 10'h001; // see [R3]
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      refresh_pending_out <= DRH_RESET_REFS;
    end else begin
      refresh_pending_out <= queue_q;
    end
  end

  // ***********************************************************
  // bus sequencer
  // ***********************************************************
  // arbitration between refresh, system master and local access
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q          <= DRH_ST_IDLE;
      hold_request_out <= 1'b0;
      cnt_q            <= 3'h0;
      gap_q            <= 2'h0;
      beats_q          <= 4'h0;
      sys_done_out     <= 1'b0;
      local_go_out     <= 1'b0;
      refresh_go_out   <= 1'b0;
      master_busy_out  <= 1'b0;
    end else begin
      sys_done_out   <= 1'b0;
      local_go_out   <= 1'b0;
      refresh_go_out <= 1'b0;
      case (state_q)
        DRH_ST_IDLE: begin
          if (queue_q != 2'h0) begin
            state_q        <= DRH_ST_REF;
            cnt_q          <= DRH_REF_LEN - 3'h1;
            refresh_go_out <= 1'b1;
          end else if (sys_req_in && master_enable_in) begin // see [R10]
            hold_request_out <= 1'b1; // see [R12]
            state_q          <= DRH_ST_WAIT;
          end else if (local_req_in) begin
            local_go_out <= 1'b1; // see [R16]
          end
        end
        DRH_ST_WAIT: begin
          if (hold_acknowledge_in) begin
            state_q         <= DRH_ST_ACC; // see [R13]
            cnt_q           <= acc_len(sys_kind_in); // see [R14]
            beats_q         <= 4'h0;
            master_busy_out <= 1'b1;
          end
        end
        DRH_ST_ACC: begin
          if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
          end else begin
            sys_done_out <= 1'b1;
            if (beats_q != 4'hF) begin
              beats_q <= beats_q + 4'h1;
            end
            if (!hold_acknowledge_in) begin
              hold_request_out <= 1'b0; // see [R17]
              master_busy_out  <= 1'b0;
              state_q          <= DRH_ST_GAP;
              gap_q            <= DRH_GAP_LEN - 2'h1;
            end else if (queue_q != 2'h0 && ref_ok) begin
              state_q        <= DRH_ST_REF; // see [R4] [R5] [R6]
              cnt_q          <= DRH_REF_LEN - 3'h1;
              refresh_go_out <= 1'b1;
            end else if (sys_req_in) begin
              cnt_q <= acc_len(sys_kind_in); // see [R15]
            end else begin
              hold_request_out <= 1'b0; // see [R15]
              master_busy_out  <= 1'b0;
              state_q          <= DRH_ST_IDLE;
            end
          end
        end
        DRH_ST_REF: begin
          if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
          end else if (queue_q > 2'h1) begin
            cnt_q          <= DRH_REF_LEN - 3'h1; // see [R7]
            refresh_go_out <= 1'b1;
          end else if (hold_request_out && hold_acknowledge_in &&
                       sys_req_in) begin
            state_q <= DRH_ST_ACC;
            cnt_q   <= acc_len(sys_kind_in);
          end else begin
            hold_request_out <= 1'b0;
            master_busy_out  <= 1'b0;
            state_q          <= DRH_ST_IDLE;
          end
        end
        DRH_ST_GAP: begin
          if (gap_q != 2'h0) begin
            gap_q <= gap_q - 2'h1;
          end else if (sys_req_in) begin
            hold_request_out <= 1'b1; // see [R18] [R19]
            state_q          <= DRH_ST_WAIT;
          end else begin
            state_q <= DRH_ST_IDLE;
          end
        end
        default: begin
          state_q          <= DRH_ST_IDLE;
          hold_request_out <= 1'b0;
        end
      endcase
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_wp_refresh: assert property ( // see [R20]
    reg_req_in.wr && reg_req_in.addr == DRH_OFF_REFRESH && wp_refresh_in
    |=> $stable(refresh_q)) else $error("protected refresh reg changed");
  chk_no_tick_off: assert property ( // see [R2]
    disabled |-> !tick) else $error("refresh tick while disabled");
  chk_queue_cap: assert property ( // see [R7]
    tick && !ref_end && queue_q == DRH_QUEUE_MAX |=>
    queue_q == DRH_QUEUE_MAX) else $error("refresh queue overflow");
  chk_row_step: assert property ( // see [R3]
    ref_end |=> refresh_row_out == $past(refresh_row_out) + 10'h001)
    else $error("row address did not advance");
  chk_first_access: assert property ( // see [R13]
    state_q == DRH_ST_WAIT && hold_acknowledge_in |=> state_q == DRH_ST_ACC)
    else $error("access did not start after acknowledge");
  chk_single_len: assert property ( // see [R14]
    state_q == DRH_ST_WAIT && hold_acknowledge_in &&
    sys_kind_in == DRH_KIND_SINGLE |=> !sys_done_out [*4] ##1 sys_done_out)
    else $error("single access not four cycles");
  chk_gap_two: assert property ( // see [R18]
    $fell(hold_request_out) && state_q == DRH_ST_GAP |->
    !hold_request_out [*2]) else $error("request re-raised too soon");
  chk_early_drop: assert property ( // see [R17]
    acc_end && !hold_acknowledge_in |=> !hold_request_out)
    else $error("request kept after early release");
  chk_reset_refs: assert property ( // see [R8]
    $rose(strap_done_q) |-> queue_q == DRH_RESET_REFS && refresh_go_out)
    else $error("reset refresh burst missing");
endmodule : drh_refresh_hold
`default_nettype wire

// ### drh_host_model.sv
// host arbitration model that answers the hold request handshake
`default_nettype none
module drh_host_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // hold handshake and test controls
  input  wire logic       hold_request_in,
  input  wire logic       early_drop_in,
  input  wire logic [3:0] lat_in,
  output var  logic       hold_acknowledge_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  logic       dropped_q;
  // grant after lat_in cycles, let go the cycle the request falls
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_acknowledge_out <= 1'b0;
      wait_q               <= 4'h0;
      dropped_q            <= 1'b0;
    end else if (!hold_request_in) begin
      hold_acknowledge_out <= 1'b0;
      wait_q               <= 4'h0;
      dropped_q            <= 1'b0;
    end else if (early_drop_in) begin
      hold_acknowledge_out <= 1'b0;
      dropped_q            <= 1'b1;
    end else if (!dropped_q && wait_q >= lat_in) begin
      hold_acknowledge_out <= 1'b1;
    end else if (!dropped_q) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule  // drh_host_model
`default_nettype wire

// ### tb_dram_refresh_and_bus_hold.sv
// testbench of the refresh scheduler and bus hold unit
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_dram_refresh_and_bus_hold;
  import drh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************************************************
  // signals
  // ***********************************************************
  logic clk, rst_n, wp_ref, wp_mem, byte_high_enable_strap, memory_io_strap, m_en, sreq, blk, lreq, edrop;
  logic ack, done, lgo, busy, hold_request, rgo;
  drh_reg_req_t req;
  drh_kind_t    kind;
  drh_mode_t    mode, style;
  logic [15:0]  rdata, memctl, e16;
  logic [9:0]   row;
  logic [1:0]   pend;
  logic [3:0]   lat;
  logic [31:0]  cyc, done_t, seed, t1, t2;
  logic         rd_p, done_v;
  logic [15:0]  exp_q[$];
  logic [2:0]   gap_q[$];
  logic [2:0]   g3;
  int           failures, comparisons, n, dn;
  drh_refresh_hold i_dut (.core_clk_in(clk), .reset_n_in(rst_n),
    .reg_req_in(req), .reg_rdata_out(rdata), .wp_refresh_in(wp_ref),
    .wp_memctl_in(wp_mem), .memctl_out(memctl),
    .byte_high_enable_strap_in(byte_high_enable_strap), .memory_io_strap_in(memory_io_strap),
    .master_enable_in(m_en), .bus_mode_out(mode), .master_style_out(style),
    .sys_req_in(sreq), .sys_kind_in(kind), .block_in(blk),
    .local_req_in(lreq), .sys_done_out(done), .local_go_out(lgo),
    .master_busy_out(busy), .hold_request_out(hold_request),
    .hold_acknowledge_in(ack), .refresh_go_out(rgo),
    .refresh_row_out(row), .refresh_pending_out(pend));
  drh_host_model i_host (.clk_in(clk), .reset_n_in(rst_n),
    .hold_request_in(hold_request), .early_drop_in(edrop), .lat_in(lat),
    .hold_acknowledge_out(ack));
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ***********************************************************
  // monitor: takes the oldest note whenever a result shows
  // ***********************************************************
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (rd_p && exp_q.size() > 0) begin
      e16 = exp_q.pop_front();
      `CHK(rdata, e16)
    end
    rd_p <= req.rd;
    if (!hold_request) begin
      done_v <= 1'b0;
    end else if (done) begin
      if (done_v && gap_q.size() > 0) begin
        g3 = gap_q.pop_front();
        `CHK(cyc - done_t, {29'h0, g3})
      end
      done_v <= 1'b1;
      done_t <= cyc;
    end
  end
  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic report_and_stop();
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic give_up();
    failures++;
    report_and_stop();
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic reg_rd(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
  endtask
  // wait for a level on hold request, bounded
  task automatic wait_hold_request(input logic lv);
    n = 0;
    do begin @(posedge clk); n++; end while (hold_request !== lv && n < 60);
    if (n >= 60) give_up();
  endtask
  task automatic wait_go(output logic [31:0] t);
    n = 0;
    do begin @(posedge clk); n++; end while (rgo !== 1'b1 && n < 400);
    t = cyc;
    if (n >= 400) give_up();
  endtask
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    {rst_n, wp_ref, wp_mem, byte_high_enable_strap, memory_io_strap, sreq, blk, lreq, edrop} = '0;
    m_en = 1'b1;
    req = '0;
    kind = DRH_KIND_SINGLE;
    lat = 4'h3;
    cyc = 32'h0;
    done_t = 32'h0;
    {rd_p, done_v} = '0;
    seed = 32'h8EB9;
    // strap decode and the three refreshes after each reset
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      byte_high_enable_strap <= m[1] ^ 1'b1;
      memory_io_strap <= m[0];
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      dn = 0;
      repeat (40) begin @(posedge clk); dn += (rgo === 1'b1); end
      `CHK(dn, 3)
      `CHK(row, 10'h003)
      `CHK(mode, (m < 2) ? m[1:0] : 2'h2)
      `CHK(style, DRH_MODE_SYNC_A)
    end
    // register reset values, unmapped place, write protect
    seed = xs(seed);
    reg_rd(DRH_OFF_REFRESH, DRH_REFRESH_RST);
    reg_rd(DRH_OFF_MEMCTL, DRH_MEMCTL_RST);
    reg_wr(7'h0A, seed[15:0]);
    reg_rd(7'h0A, 16'h0000);
    reg_wr(DRH_OFF_MEMCTL, seed[15:0]);
    reg_rd(DRH_OFF_MEMCTL, seed[15:0]);
    wp_mem <= 1'b1;
    reg_wr(DRH_OFF_MEMCTL, ~seed[15:0]);
    reg_rd(DRH_OFF_MEMCTL, seed[15:0]);
    `CHK(memctl, seed[15:0])
    // refresh interval for two scalar values
    for (int s = 0; s < 2; s++) begin
      reg_wr(DRH_OFF_REFRESH, 16'hFFC0 | 16'(s * 3));
      reg_rd(DRH_OFF_REFRESH, 16'(s * 3));
      wait_go(t1);
      wait_go(t1);
      wait_go(t2);
      `CHK(t2 - t1, 32'(DRH_PRESCALE * (s * 3 + 1)))
    end
    // all ones stops refresh, then protect locks it
    reg_wr(DRH_OFF_REFRESH, DRH_REFRESH_MSK);
    repeat (100) @(posedge clk);
    dn = 0;
    repeat (1100) begin @(posedge clk); dn += (rgo === 1'b1); end
    `CHK(dn, 0)
    wp_ref <= 1'b1;
    reg_wr(DRH_OFF_REFRESH, 16'h0000);
    reg_rd(DRH_OFF_REFRESH, DRH_REFRESH_MSK);
    // back-to-back master accesses of every kind, prompt and slow host
    for (int k = 0; k < 3; k++) begin
      g3 = (k == 0) ? DRH_LEN_SINGLE : (k == 1) ? DRH_LEN_RMW : DRH_LEN_BURST;
      repeat (3) gap_q.push_back(g3);
      @(posedge clk);
      lat <= 4'(k * 4);
      kind <= drh_kind_t'(k);
      sreq <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (gap_q.size() > 0 && n < 100);
      if (n >= 100) give_up();
      `CHK(hold_request, 1'b1)
      sreq <= 1'b0;
      lreq <= 1'b1;
      wait_hold_request(1'b0);
      dn = 0;
      repeat (2) begin @(posedge clk); dn += (lgo === 1'b1); end
      `CHK(dn > 0, 1'b1)
      lreq <= 1'b0;
    end
    // early release by the host mid-run
    @(posedge clk);
    lat <= 4'h2;
    kind <= DRH_KIND_SINGLE;
    sreq <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 60);
    if (n >= 60) give_up();
    edrop <= 1'b1;
    @(posedge clk);
    edrop <= 1'b0;
    dn = 0;
    n = 0;
    while (hold_request !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
      dn += (done === 1'b1);
    end
    `CHK(dn < 2, 1'b1)
    n = 0;
    while (hold_request === 1'b0 && n < 10) begin @(posedge clk); n++; end
    `CHK(n, int'(DRH_GAP_LEN))
    sreq <= 1'b0;
    wait_hold_request(1'b0);
    // slave only: no hold request at all
    m_en <= 1'b0;
    sreq <= 1'b1;
    dn = 0;
    repeat (50) begin @(posedge clk); dn += (hold_request !== 1'b0); end
    `CHK(dn, 0)
    sreq <= 1'b0;
    report_and_stop();
  end
endmodule  // tb_dram_refresh_and_bus_hold
`default_nettype wire
